// *** src/serial_port.sv ***
// Asynchronous serial transmitter and receiver with 16x oversampling.
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_regs.svh"
module serial_port
    import serial_port_pkg::*;
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      rst_b,
    // Configuration
    input  wire port_cfg_s cfg,
    // Host data path
    input  wire logic      tx_write,
    input  wire logic [7:0] tx_data,
    input  wire logic      tx_ninth_bit,
    input  wire logic      rx_read,
    // Serial pins
    input  wire logic      rx_in,
    output var  logic      tx_out,
    output var  logic      tx_oe,
    // Status and received data
    output var  logic      tx_empty_flag,
    output var  logic      tx_complete_flag,
    output var  rx_flags_s rx_flags,
    output var  logic [7:0] data_buffer,
    output var  logic      rx_ninth_bit,
    output var  logic      tx_irq,
    output var  logic      rx_irq
);

    function automatic logic maj3(input logic [2:0] s);
        maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    function automatic logic split3(input logic [2:0] s);
        split3 = (s != 3'b000) && (s != 3'b111);
    endfunction

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////////
    // Sample clock enable.
    logic [7:0] div_cnt;
    logic       sample_tick;
    logic [3:0] tx_rt;
    logic       bit_tick;

    always_ff @(posedge clk)
    begin
        if (!rst_b || !cfg.port_enable || div_cnt == `SAMPLE_DIV - 8'h01)
            div_cnt <= 8'h00;
        else
            div_cnt <= div_cnt + 8'h01;
    end

    assign sample_tick = cfg.port_enable && (div_cnt == `SAMPLE_DIV - 8'h01); // [R19]

    always_ff @(posedge clk)
    begin
        if (!rst_b || !cfg.port_enable)
            tx_rt <= `RT_FIRST;
        else if (sample_tick)
            tx_rt <= tx_rt + 4'h1;
    end

    assign bit_tick = sample_tick && (tx_rt == `RT_16); // [R25]

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter.
    tx_state_e  tx_state;
    tx_load_e   next_load;
    logic [10:0] tx_shift;
    logic [3:0] tx_left;
    logic [3:0] frame_len;
    logic [7:0] tx_hold;
    logic       tx_hold_ninth;
    logic       last_break;
    logic       te_dropped;
    logic       idle_queued;
    logic       tx_point;
    logic       tx_line;

    assign frame_len = cfg.nine_bit_select ? `FRAME_LEN_9 : `FRAME_LEN_8; // [R01]
    assign tx_point  = bit_tick && (tx_state != TX_SEND || tx_left == 4'h1);
    assign tx_line   = (tx_state == TX_SEND) ? tx_shift[0] : 1'b1; // [R06]

    // The load decision is taken only on a bit boundary, so that every
    // character starts aligned to the free-running bit timer.
    always_comb
    begin
        next_load = LD_NONE;
        if (tx_point)
        begin
            if (tx_state == TX_OFF)
                next_load = cfg.tx_enable ? LD_PRE : LD_NONE; // [R03] [R12]
            else if (!cfg.tx_enable && !last_break)
                next_load = LD_OFF; // [R13]
            else if (cfg.send_break && cfg.tx_enable)
                next_load = LD_BREAK; // [R08]
            else if (last_break)
                next_load = LD_ONE; // [R09]
            else if (idle_queued)
                next_load = LD_IDLE; // [R14]
            else if (!tx_empty_flag)
                next_load = LD_DATA;
            else
                next_load = LD_WAIT;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b || !cfg.port_enable)
        begin
            tx_state <= TX_OFF; // [R07]
            tx_shift <= 11'h7FF;
            tx_left  <= 4'h0;
            last_break <= 1'b0;
        end
        else
        begin
            unique case (next_load)
                LD_NONE:
                begin
                    if (bit_tick && tx_state == TX_SEND)
                    begin
                        tx_shift <= {1'b1, tx_shift[10:1]}; // [R25]
                        tx_left  <= tx_left - 4'h1;
                    end
                end
                LD_PRE, LD_IDLE:
                begin
                    tx_shift <= 11'h7FF;
                    tx_left  <= frame_len;
                    tx_state <= TX_SEND;
                    last_break <= 1'b0;
                end
                LD_BREAK:
                begin
                    tx_shift <= 11'h000;
                    tx_left  <= frame_len;
                    tx_state <= TX_SEND;
                    last_break <= 1'b1;
                end
                LD_ONE:
                begin
                    tx_shift <= 11'h7FF;
                    tx_left  <= 4'h1;
                    tx_state <= TX_SEND;
                    last_break <= 1'b0;
                end
                LD_DATA:
                begin
                    tx_shift <= cfg.nine_bit_select ? {1'b1, tx_hold_ninth, tx_hold, 1'b0}
                                                    : {2'b11, tx_hold, 1'b0}; // [R04] [R01]
                    tx_left  <= frame_len;
                    tx_state <= TX_SEND;
                end
                LD_WAIT: tx_state <= TX_WAIT;
                LD_OFF:  tx_state <= TX_OFF;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b || !cfg.port_enable)
        begin
            te_dropped  <= 1'b0;
            idle_queued <= 1'b0;
        end
        else if (next_load == LD_IDLE || next_load == LD_OFF)
        begin
            te_dropped  <= 1'b0;
            idle_queued <= 1'b0;
        end
        else if (tx_state == TX_SEND)
        begin
            if (!cfg.tx_enable)
                te_dropped <= 1'b1;
            else if (te_dropped)
            begin
                te_dropped  <= 1'b0;
                idle_queued <= 1'b1; // [R14]
            end
        end
    end

    // A host write in the same cycle as a load is dropped and the flag is
    // set, so the host still sees a free buffer and writes again.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            tx_empty_flag <= 1'b1;
            tx_hold       <= 8'h00;
            tx_hold_ninth <= 1'b0;
        end
        else if (next_load == LD_DATA)
            tx_empty_flag <= 1'b1; // [R05]
        else if (tx_write)
        begin
            tx_empty_flag <= 1'b0;
            tx_hold       <= tx_data;
            tx_hold_ninth <= tx_ninth_bit; // [R01]
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            tx_out           <= 1'b1;
            tx_oe            <= 1'b0;
            tx_complete_flag <= 1'b1;
            tx_irq           <= 1'b0;
        end
        else
        begin
            tx_out <= tx_line ^ cfg.tx_polarity_invert; // [R16]
            tx_oe  <= cfg.port_enable; // [R07]
            tx_complete_flag <= (tx_state != TX_SEND) && tx_empty_flag && !tx_write; // [R17]
            tx_irq <= (cfg.tx_empty_irq_en && tx_empty_flag)
                   || (cfg.tx_done_irq_en && tx_complete_flag); // [R05] [R17]
        end
    end

    a_idle_line_level: assert property (tx_state != TX_SEND
        |=> tx_out == !$past(cfg.tx_polarity_invert)) // [R06] [R16]
        else $error("idle line not at idle level");
    a_break_all_zero: assert property (next_load == LD_BREAK
        |=> tx_shift == 11'h000 && tx_left == $past(frame_len)) // [R08]
        else $error("break character not all zeros");
    a_preamble_ones: assert property (next_load == LD_PRE
        |=> tx_shift == 11'h7FF && tx_state == TX_SEND) // [R03]
        else $error("preamble not all ones");
    a_frame_bounds: assert property (next_load == LD_DATA
        |=> !tx_shift[0] && tx_shift[$past(frame_len) - 4'h1] && tx_empty_flag) // [R04] [R05]
        else $error("frame start or stop bit wrong");
    a_port_release: assert property (!cfg.port_enable |=> !tx_oe ##1 tx_state == TX_OFF) // [R07]
        else $error("pin not released");

    ////////////////////////////////////////////////////////////////////////////
    // Receiver.
    rx_state_e  rx_state;
    logic [3:0] rx_rt;
    logic [3:0] rt_now;
    logic [2:0] hunt_hist;
    logic [2:0] votes;
    logic [2:0] sample_set;
    logic [3:0] bit_idx;
    logic [3:0] data_bits;
    logic [8:0] rx_shift;
    logic       prev_bit;
    logic       edge_seen;
    logic [3:0] edge_pos;
    logic       rx_done;
    logic       rx_is_break;
    logic       voted;
    logic       bit_decided;
    logic       at_decide;

    assign rt_now     = rx_rt + 4'h1;
    assign sample_set = {votes[1:0], rx_in};
    assign voted      = maj3(sample_set);
    assign data_bits  = cfg.nine_bit_select ? `DATA_BITS_9 : `DATA_BITS_8; // [R01]
    assign at_decide  = (rt_now == `RT_10) && !bit_decided;
    assign rx_done    = sample_tick && rx_state == RX_DATA && at_decide
                     && bit_idx == data_bits;
    assign rx_is_break = rx_done && !voted && rx_shift == 9'h000; // [R10]

    always_ff @(posedge clk)
    begin
        if (!rst_b || !cfg.port_enable)
        begin
            rx_state  <= RX_HUNT; // [R07]
            rx_rt     <= `RT_FIRST;
            hunt_hist <= 3'b000;
            votes     <= 3'b000;
            bit_idx   <= 4'h0;
            rx_shift  <= 9'h000;
            prev_bit  <= 1'b0;
            edge_seen <= 1'b0;
            edge_pos  <= 4'h0;
            bit_decided <= 1'b0;
        end
        else if (sample_tick)
        begin
            unique case (rx_state)
                RX_HUNT:
                begin
                    hunt_hist <= {hunt_hist[1:0], rx_in};
                    if (hunt_hist == 3'b111 && !rx_in)
                    begin
                        rx_state <= RX_START; // [R21] [R20]
                        rx_rt    <= `RT_FIRST;
                        rx_shift <= 9'h000;
                        prev_bit <= 1'b0;
                        bit_decided <= 1'b0;
                    end
                end
                RX_START:
                begin
                    rx_rt <= rt_now;
                    if (rt_now == `RT_3 || rt_now == `RT_5 || rt_now == `RT_7)
                        votes <= sample_set;
                    if (rt_now == `RT_7 && voted)
                    begin
                        rx_state  <= RX_HUNT; // [R22]
                        hunt_hist <= 3'b000;
                    end
                    else if (rt_now == `RT_16)
                    begin
                        rx_state <= RX_DATA;
                        bit_idx  <= 4'h0;
                    end
                end
                RX_DATA:
                begin
                    rx_rt <= rt_now;
                    if (rt_now == `RT_8 || rt_now == `RT_9)
                        votes <= sample_set;
                    if (prev_bit && !rx_in && !edge_seen && rt_now <= `RT_10)
                    begin
                        edge_seen <= 1'b1;
                        edge_pos  <= rt_now;
                    end
                    if (rt_now == `RT_16)
                        bit_decided <= 1'b0;
                    // A late edge pulls the count back below RT10; the guard
                    // keeps that bit from being decided a second time.
                    if (at_decide)
                    begin
                        bit_decided <= 1'b1;
                        edge_seen <= 1'b0;
                        prev_bit  <= voted; // [R23]
                        if (prev_bit && !voted && edge_seen)
                            rx_rt <= `RT_10 - edge_pos; // [R20]
                        if (bit_idx == data_bits)
                        begin
                            rx_state  <= RX_HUNT;
                            hunt_hist <= voted ? 3'b111 : 3'b000;
                        end
                        else
                        begin
                            rx_shift[bit_idx] <= voted; // [R25]
                            bit_idx <= bit_idx + 4'h1;
                        end
                    end
                end
                default: rx_state <= RX_HUNT;
            endcase
        end
    end

    // Flags keep their set over a same-cycle host read so no event is lost.
    logic noise_hit;
    assign noise_hit = sample_tick && (
        (rx_state == RX_START && rt_now == `RT_7 && split3(sample_set) && !voted) // [R22]
        || (rx_state == RX_DATA && at_decide && split3(sample_set))); // [R23] [R24]

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rx_flags     <= '0;
            data_buffer  <= 8'h00;
            rx_ninth_bit <= 1'b0;
            rx_irq       <= 1'b0;
        end
        else
        begin
            rx_flags.rx_active_flag <= cfg.port_enable && rx_state != RX_HUNT;
            rx_irq <= cfg.rx_full_irq_en && rx_flags.rx_full_flag; // [R18]
            if (rx_read)
            begin
                rx_flags.rx_full_flag       <= 1'b0;
                rx_flags.framing_error_flag <= 1'b0;
                rx_flags.noise_flag         <= 1'b0;
                rx_flags.break_flag         <= 1'b0;
                rx_flags.overrun_flag       <= 1'b0;
            end
            if (noise_hit)
                rx_flags.noise_flag <= 1'b1;
            if (rx_done)
            begin
                rx_flags.rx_full_flag       <= 1'b1; // [R18]
                rx_flags.framing_error_flag <= !voted; // [R24] [R11]
                rx_flags.break_flag         <= rx_is_break; // [R11]
                if (rx_flags.rx_full_flag && !rx_read)
                    rx_flags.overrun_flag <= 1'b1;
                else if (rx_is_break)
                begin
                    data_buffer  <= 8'h00; // [R11]
                    rx_ninth_bit <= 1'b0;
                end
                else
                begin
                    data_buffer  <= rx_shift[7:0];
                    rx_ninth_bit <= cfg.nine_bit_select ? rx_shift[8] : rx_shift[7]; // [R01]
                end
            end
        end
    end

    a_start_abort: assert property (sample_tick && rx_state == RX_START && rt_now == `RT_7
        && voted |=> rx_state == RX_HUNT && hunt_hist == 3'b000) // [R22]
        else $error("failed start check not aborted");
    a_rx_full_set: assert property (rx_done |=> rx_flags.rx_full_flag
        ##1 rx_flags.rx_active_flag == (rx_state != RX_HUNT)) // [R18]
        else $error("receive full not set");
    a_stop_framing: assert property (rx_done && !voted
        |=> rx_flags.framing_error_flag && rx_flags.rx_full_flag) // [R24]
        else $error("framing error not flagged");
    a_break_clears: assert property (rx_is_break && !rx_flags.rx_full_flag
        |=> data_buffer == 8'h00 && !rx_ninth_bit && rx_flags.break_flag) // [R11] [R10]
        else $error("break did not clear data");
    a_rt_on_tick: assert property (rx_state != RX_HUNT && !sample_tick && cfg.port_enable
        |=> $stable(rx_rt)) // [R19]
        else $error("sample count moved off tick");

endmodule // serial_port
`default_nettype wire

// *** src/serial_port_regs.svh ***
// Timing counts, sample positions and frame lengths of the serial port.
// How it works
// [R01] Characters are 8 or 9 bits by nine_bit_select; ninth bit handled both ways.
// [R02] Host sets port_enable, then tx_enable, then writes data_buffer per character.
// [R03] Every transmission starts with an idle preamble before buffer data is loaded.
// [R04] Frames carry a 0 start bit at the bottom and 1 stop bit on top.
// [R05] Loading the shift register sets tx_empty_flag and may raise the transmit interrupt.
// [R06] The transmit line rests at logic 1 whenever no character is shifting.
// [R07] Clearing port_enable releases both port pins at once.
// [R08] While send_break is high, all-zero break characters are sent back to back.
// [R09] After send_break clears, the break finishes and at least one 1 follows.
// [R10] Start, all-zero data and zero stop bit are taken as a break.
// [R11] A break sets framing, full and break flags and clears the received data.
// [R12] An idle character is all ones, frame length, no start or stop bit.
// [R13] Dropping tx_enable mid-character completes that character, then the line idles.
// [R14] Dropping and raising tx_enable during a character queues one idle character.
// [R15] Host must raise tx_enable again before the stop bit, or data is lost. The code keeps the unsent byte in tx_hold and sends it after a preamble.
// [R16] tx_polarity_invert inverts every transmitted level, idle and break included.
// [R17] tx_complete_flag is set when shifter and buffer are empty, may interrupt.
// [R18] A completed character moves to data_buffer and sets rx_full_flag.
// [R19] The receiver samples the line at sixteen times the baud rate.
// [R20] The sample count is realigned at every start bit and 1-to-0 data edge.
// [R21] A zero after three ones is a start edge; the sample count restarts.
// [R22] Start check uses samples 3, 5, 7; two ones abort, one one is noise.
// [R23] Data bits are the majority of samples 8, 9, 10; disagreement is noise.
// [R24] Stop majority zero sets framing_error_flag with rx_full_flag; disagreement is noise.
// [R25] Data goes least significant bit first, sixteen samples per bit.
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH
`define SAMPLE_DIV   8'h0D
`define RT_FIRST     4'h0
`define RT_3         4'h2
`define RT_5         4'h4
`define RT_7         4'h6
`define RT_8         4'h7
`define RT_9         4'h8
`define RT_10        4'h9
`define RT_16        4'hF
`define FRAME_LEN_8  4'hA
`define FRAME_LEN_9  4'hB
`define DATA_BITS_8  4'h8
`define DATA_BITS_9  4'h9
`endif

// *** src/serial_port_pkg.sv ***
// Types shared by the serial port design.
package serial_port_pkg;
    typedef struct packed {
        logic port_enable;
        logic tx_enable;
        logic nine_bit_select;
        logic send_break;
        logic tx_polarity_invert;
        logic tx_empty_irq_en;
        logic tx_done_irq_en;
        logic rx_full_irq_en;
    } port_cfg_s;
    typedef struct packed {
        logic rx_full_flag;
        logic framing_error_flag;
        logic noise_flag;
        logic break_flag;
        logic overrun_flag;
        logic rx_active_flag;
    } rx_flags_s;
    typedef enum logic [1:0] {TX_OFF = 2'b00, TX_WAIT = 2'b01, TX_SEND = 2'b10} tx_state_e;
    typedef enum logic [2:0] {
        LD_NONE = 3'b000, LD_PRE = 3'b001, LD_BREAK = 3'b010, LD_ONE = 3'b011,
        LD_IDLE = 3'b100, LD_DATA = 3'b101, LD_WAIT = 3'b110, LD_OFF = 3'b111
    } tx_load_e;
    typedef enum logic [1:0] {RX_HUNT = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10} rx_state_e;
endpackage

// *** dv/remote_serial.sv ***
// Remote serial device model: drives the receive line, decodes the transmit line.
`timescale 1ns/100ps
`default_nettype none
module remote_serial
(
    // Clock
    input  wire logic clk,
    // Serial lines
    input  wire logic line_in,
    input  wire logic invert,
    output var  logic line_out
);
    localparam int BIT_CLKS = 208;
    initial line_out = 1'b1;
    ////////////////////////////////////////////////////////////////////////////
    // Caller stands on a falling edge; the line changes there and holds.
    task automatic hold(input logic lvl, input int clks);
        line_out = lvl;
        repeat (clks) @(negedge clk);
    endtask
    // Sends nb bits LSB first; gbit flips one sample-wide slice at mid-bit.
    task automatic send(input logic [10:0] bits, input int nb, input int gbit);
        @(negedge clk);
        hold(1'b1, 64);
        for (int i = 0; i < nb; i++)
        begin
            if (i == gbit)
            begin
                hold(bits[i], 104);
                hold(~bits[i], 13);
                hold(bits[i], 91);
            end
            else
                hold(bits[i], BIT_CLKS);
        end
        line_out = 1'b1;
    endtask
    // Waits for a start edge, then samples every bit at its middle.
    task automatic get(input int nb, output logic [10:0] bits, output int idle);
        idle = 0;
        bits = '0;
        while ((line_in ^ invert) !== 1'b0)
        begin
            @(negedge clk);
            idle++;
        end
        repeat (BIT_CLKS / 2) @(negedge clk);
        for (int i = 0; i < nb; i++)
        begin
            bits[i] = line_in ^ invert;
            if (i < nb - 1)
                repeat (BIT_CLKS) @(negedge clk);
        end
        @(negedge clk);
    endtask
endmodule // remote_serial
`default_nettype wire

// *** dv/serial_port_test.sv ***
// Self-checking testbench of the serial port with a remote device model.
`timescale 1ns/100ps
`default_nettype none
module serial_port_test
    import serial_port_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        tx_write = 1'b0;
    logic        tx_ninth_bit = 1'b0;
    logic        rx_read = 1'b0;
    logic [7:0]  tx_data = 8'h00;
    port_cfg_s   cfg = '0;
    logic        rx_in, tx_out, tx_oe, tx_empty_flag, tx_complete_flag;
    logic        rx_ninth_bit, tx_irq, rx_irq;
    logic [7:0]  data_buffer;
    rx_flags_s   rx_flags;
    logic [10:0] got;
    int          idle;
    int          bad_count = 0;
    int          n_tests = 0;
    int          cycles = 0;
    always #20 clk = ~clk;
    serial_port dut (.clk, .rst_b, .cfg, .tx_write, .tx_data, .tx_ninth_bit, .rx_read,
        .rx_in, .tx_out, .tx_oe, .tx_empty_flag, .tx_complete_flag, .rx_flags,
        .data_buffer, .rx_ninth_bit, .tx_irq, .rx_irq);
    remote_serial part (.clk(clk), .line_in(tx_out), .invert(cfg.tx_polarity_invert),
        .line_out(rx_in));
    ////////////////////////////////////////////////////////////////////////////
    // A hung wait ends the run here rather than running forever.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            bad_count++;
            $display("[FAIL] %0t timeout", $time);
            results();
        end
    end
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_bit(input logic g, input logic e, input string m);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic chk_vec(input logic [10:0] g, input logic [10:0] e, input string m);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic chk_ge(input int g, input int lo, input string m);
        n_tests++;
        if (g < lo)
        begin
            bad_count++;
            $display("[FAIL] %0t %s %0d", $time, m, g);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [8:0] d);
        tx_data = d[7:0];
        tx_ninth_bit = d[8];
        tx_write = 1'b1;
        tick(1);
        tx_write = 1'b0;
        tick(2);
    endtask
    task automatic rd();
        rx_read = 1'b1;
        tick(1);
        rx_read = 1'b0;
    endtask
    function automatic logic [10:0] mk(input logic [8:0] d, input logic nine);
        return nine ? {1'b1, d, 1'b0} : {2'b01, d[7:0], 1'b0};
    endfunction
    task automatic tx_chk(input int nb, input logic [10:0] e, input int lo);
        part.get(nb, got, idle);
        chk_vec(got, e, "tx frame");
        chk_ge(idle, lo, "tx idle");
    endtask
    task automatic rx_chk(input logic [8:0] d, input logic full, input logic fe);
        tick(2);
        chk_vec({2'b00, rx_ninth_bit, data_buffer}, {2'b00, d}, "rx data");
        chk_bit(rx_flags.rx_full_flag, full, "rx full");
        chk_bit(rx_flags.framing_error_flag, fe, "framing");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(20);
        rst_b = 1'b1;
        tick(1);
        chk_bit(tx_out, 1'b1, "idle level");
        chk_bit(tx_oe, 1'b0, "oe at reset");
        chk_bit(tx_complete_flag, 1'b1, "complete at reset");
        cfg.port_enable = 1'b1;
        cfg.tx_done_irq_en = 1'b1;
        cfg.rx_full_irq_en = 1'b1;
        tick(2);
        chk_bit(tx_oe, 1'b1, "oe on");
        cfg.tx_enable = 1'b1;
        wr(9'h0A5);
        chk_bit(tx_empty_flag, 1'b0, "empty after write");
        chk_bit(tx_complete_flag, 1'b0, "complete busy");
        tx_chk(10, mk(9'h0A5, 1'b0), 10 * 208 - 8);
        chk_bit(tx_empty_flag, 1'b1, "empty on load");
        wr(9'h03C);
        fork
            tx_chk(10, mk(9'h03C, 1'b0), 0);
            begin
                while (tx_out !== 1'b0) tick(1);
                tick(300);
                cfg.tx_enable = 1'b0;
                tick(1);
                cfg.tx_enable = 1'b1;
            end
        join
        wr(9'h066);
        tx_chk(10, mk(9'h066, 1'b0), 10 * 208);
        cfg.tx_enable = 1'b0;
        tick(200);
        chk_bit(tx_complete_flag, 1'b1, "complete");
        chk_bit(tx_irq, 1'b1, "done irq");
        wr(9'h000);
        tick(11 * 208 * 2);
        chk_bit(tx_out, 1'b1, "idle while off");
        chk_bit(tx_empty_flag, 1'b0, "held byte");
        cfg.nine_bit_select = 1'b1;
        cfg.tx_polarity_invert = 1'b1;
        cfg.tx_done_irq_en = 1'b0;
        cfg.tx_empty_irq_en = 1'b1;
        tick(2);
        chk_bit(tx_out, 1'b0, "inverted idle");
        cfg.tx_enable = 1'b1;
        wr(9'h15A);
        chk_bit(tx_irq, 1'b0, "no empty irq");
        tx_chk(11, mk(9'h15A, 1'b1), 11 * 208 - 8);
        chk_bit(tx_irq, 1'b1, "empty irq");
        cfg.send_break = 1'b1;
        tick(12 * 208);
        chk_bit(tx_out, 1'b1, "break level");
        chk_bit(tx_complete_flag, 1'b0, "complete in break");
        cfg.send_break = 1'b0;
        while (tx_out !== 1'b0) tick(1);
        tick(150);
        chk_bit(tx_out, 1'b0, "one after break");
        tick(300);
        cfg.tx_polarity_invert = 1'b0;
        cfg.nine_bit_select = 1'b0;
        cfg.port_enable = 1'b0;
        tick(2);
        chk_bit(tx_oe, 1'b0, "oe released");
        cfg.port_enable = 1'b1;
        tick(2);
        part.send(mk(9'h0C3, 1'b0), 10, -1);
        rx_chk(9'h1C3, 1'b1, 1'b0);
        chk_bit(rx_irq, 1'b1, "rx irq");
        rd();
        cfg.nine_bit_select = 1'b1;
        part.send(mk(9'h081, 1'b1), 11, -1);
        rx_chk(9'h081, 1'b1, 1'b0);
        rd();
        cfg.nine_bit_select = 1'b0;
        part.send(mk(9'h0FF, 1'b0), 10, 4);
        rx_chk(9'h1FF, 1'b1, 1'b0);
        chk_bit(rx_flags.noise_flag, 1'b1, "noise");
        rd();
        part.send({2'b00, 8'h55, 1'b0}, 10, -1);
        rx_chk(9'h055, 1'b1, 1'b1);
        chk_bit(rx_flags.break_flag, 1'b0, "no break");
        rd();
        part.send(11'h000, 10, -1);
        rx_chk(9'h000, 1'b1, 1'b1);
        chk_bit(rx_flags.break_flag, 1'b1, "break");
        rd();
        part.hold(1'b1, 64);
        part.hold(1'b0, 39);
        part.hold(1'b1, 3000);
        chk_bit(rx_flags.rx_full_flag, 1'b0, "false start");
        part.send(mk(9'h05A, 1'b0), 10, -1);
        rx_chk(9'h05A, 1'b1, 1'b0);
        rd();
        part.hold(1'b1, 64);
        part.hold(1'b0, 52);
        part.hold(1'b1, 13);
        part.hold(1'b0, 143);
        part.hold(1'b1, 247);
        part.hold(1'b0, 208);
        part.hold(1'b1, 208);
        part.hold(1'b0, 5 * 208);
        part.hold(1'b1, 208);
        rx_chk(9'h005, 1'b1, 1'b0);
        chk_bit(rx_flags.noise_flag, 1'b1, "start noise");
        part.send(mk(9'h0AA, 1'b0), 10, -1);
        rx_chk(9'h005, 1'b1, 1'b0);
        chk_bit(rx_flags.overrun_flag, 1'b1, "overrun");
        results();
    end
endmodule // serial_port_test
`default_nettype wire
